/* hdl/nibble_bus_cfg.svh */
// Constants for the nibble bus master: timing, command codes, vectors.
`ifndef NIBBLE_BUS_CFG_SVH
`define NIBBLE_BUS_CFG_SVH

// Clock and strobe timing
`define CLK_SYS_HZ 200000000
`define STROBE_HZ 640000
`define STROBE_HALF_CYC ((`CLK_SYS_HZ / `STROBE_HZ) / 2)

// Bus geometry
`define NIBBLE_W 4
`define ADDR_NIBBLES 5
`define MAX_WORD_NIBBLES 16
`define SENSE_LINES 16
`define DRIVE_LINES 12
`define SENSE_KEY_ON_BIT 15
`define SENSE_GENERAL_ONLY_BIT 14

// Command nibbles sent with command_data_select low
`define CMD_LOAD_CODE_PTR 4'h4
`define CMD_LOAD_DATA_PTR 4'h5
`define CMD_READ 4'h3
`define CMD_WRITE 4'h2

// Module interrupt entry point
`define INT_VECTOR 20'h0000f

// Reset values
`define DRIVE_LINES_RST 12'h000
`define IDLE_NIBBLE 4'h0

`endif

/* hdl/nibble_bus_pkg.sv */
// Types for the nibble bus master.
package nibble_bus_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_HALT = 3'b100
  } bus_state_t;

  typedef enum logic [1:0] {
    XFER_LOAD_CODE = 2'b00,
    XFER_LOAD_DATA = 2'b01,
    XFER_READ = 2'b10,
    XFER_WRITE = 2'b11
  } xfer_kind_t;

endpackage

/* hdl/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter, one per bit.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      // First stage is read only by the second
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          s1_q <= RST_VAL[i];
          s2_q <= RST_VAL[i];
          s3_q <= RST_VAL[i];
        end else begin
          s1_q <= pin_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // A change counts once stages two and three agree
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          level_q[i] <= RST_VAL[i];
        end else if (s2_q == s3_q) begin
          level_q[i] <= s3_q;
        end
      end
    end
  endgenerate

endmodule

/* hdl/nibble_bus_master_interface.sv */
// Bus-master end of the four-bit multiplexed nibble bus.
`timescale 1ns/100ps
`include "nibble_bus_cfg.svh"

// Function
// RULE1 - four shared nibble lines plus two controls
// RULE2 - address goes out as five nibbles
// RULE3 - words of up to sixteen nibbles
// RULE4 - active-low strobe marks valid bus contents
// RULE5 - command driven after strobe fall, select low
// RULE6 - partners latch command on strobe rise
// RULE7 - select high for data, low for command
// RULE8 - interrupt on module line low or sense high
// RULE9 - module interrupt enters at address 0000f
// RULE10 - halt finishes transfer then releases bus
// RULE11 - external master may use bus while halted
// RULE12 - sense line fourteen is general input only
// RULE13 - twelve drive lines: keys, ports, beeper
// RULE14 - strobe timed from about 640 kHz
// RULE15 - load-pointer command then five address nibbles
// RULE16 - partners stream nibbles and bump pointers
// RULE17 - data nibbles use same strobe edges
module nibble_bus_master_interface (
  input wire logic clk_sys,
  input wire logic arst_n,
  // Transfer request side
  input wire logic req_valid,
  output logic req_ready,
  input wire nibble_bus_pkg::xfer_kind_t req_kind,
  input wire logic [19:0] req_addr,
  input wire logic [3:0] req_last,
  input wire logic [63:0] req_wdata,
  output logic done_pulse,
  output logic [63:0] rdata_q,
  // Interrupt side
  output logic int_take,
  output logic int_from_module,
  output logic [19:0] int_vector,
  output logic key_hit,
  output logic [15:0] sense_level,
  // Output register side
  input wire logic drive_we,
  input wire logic [11:0] drive_wdata,
  output logic [11:0] output_drive_lines,
  // Pins
  input wire logic [3:0] nibble_lines_in,
  output logic [3:0] nibble_lines_out,
  output logic nibble_lines_oe_n,
  output logic bus_clock_pulse_n,
  output logic bus_clock_pulse_oe_n,
  output logic command_data_select,
  output logic command_data_select_oe_n,
  input wire logic module_int_n,
  input wire logic halt,
  input wire logic [15:0] input_sense_lines,
  output logic halted
);
  import nibble_bus_pkg::*;

  localparam logic [8:0] HALF_CYC = 9'(`STROBE_HALF_CYC);
  localparam logic [2:0] ADDR_LAST = 3'(`ADDR_NIBBLES - 1);

  bus_state_t state_q;
  logic [8:0] div_q;
  logic strobe_q;
  logic fall_tick;
  logic rise_tick;
  logic pend_q;
  xfer_kind_t kind_q;
  logic [19:0] addr_q;
  logic [3:0] last_q;
  logic [63:0] wdata_q;
  logic [3:0] cnt_q;
  logic [3:0] nib_q;
  logic cd_q;
  logic int_busy_q;
  logic [3:0] bus_in_s;
  logic mod_int_n_s;
  logic halt_s;
  logic [15:0] sense_s;
  logic int_any;
  logic is_load;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pin_sync #(.WIDTH(22), .RST_VAL(22'h100000)) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_in({halt, module_int_n, input_sense_lines, nibble_lines_in}),
    .level_q({halt_s, mod_int_n_s, sense_s, bus_in_s})
  );

  ////////////////////////////////////////////////////////////////
  // Strobe divider; frozen while halted so the line is truly free
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 9'h000;
      strobe_q <= 1'b1;
    end else if (state_q == ST_HALT) begin
      div_q <= 9'h000;
      strobe_q <= 1'b1;
    end else if (div_q == HALF_CYC - 9'h001) begin
      div_q <= 9'h000;
      strobe_q <= ~strobe_q; // RULE14
    end else begin
      div_q <= div_q + 9'h001;
    end
  end

  assign fall_tick = (div_q == HALF_CYC - 9'h001) && strobe_q && (state_q != ST_HALT);
  assign rise_tick = (div_q == HALF_CYC - 9'h001) && !strobe_q && (state_q != ST_HALT);

  ////////////////////////////////////////////////////////////////
  // Request capture; one transfer held at a time
  assign req_ready = (state_q == ST_IDLE) && !pend_q && !halt_s;
  assign is_load = (kind_q == XFER_LOAD_CODE) || (kind_q == XFER_LOAD_DATA);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
      kind_q <= XFER_READ;
      addr_q <= 20'h00000;
      last_q <= 4'h0;
      wdata_q <= 64'h0;
    end else if (req_valid && req_ready) begin
      pend_q <= 1'b1;
      kind_q <= req_kind;
      addr_q <= req_addr;
      last_q <= req_last; // RULE3
      wdata_q <= req_wdata;
    end else if (fall_tick && state_q == ST_IDLE && pend_q && !int_any) begin
      pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Interrupt sources; line fourteen is not a key
  assign int_any = (!mod_int_n_s || (|sense_s)) && !int_busy_q; // RULE8
  assign key_hit = |(sense_s & ~(16'h0001 << `SENSE_GENERAL_ONLY_BIT)); // RULE12
  assign sense_level = sense_s;
  assign int_vector = `INT_VECTOR; // RULE9

  // Taken only between transfers; rearms once every source is quiet
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      int_take <= 1'b0;
      int_from_module <= 1'b0;
      int_busy_q <= 1'b0;
    end else begin
      int_take <= 1'b0;
      if (fall_tick && state_q == ST_IDLE && !halt_s && int_any) begin
        int_take <= 1'b1; // RULE9
        int_from_module <= !mod_int_n_s;
        int_busy_q <= 1'b1;
      end else if (mod_int_n_s && !(|sense_s)) begin
        int_busy_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Transfer sequencer; new nibble and select change on strobe fall
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      nib_q <= `IDLE_NIBBLE;
      cd_q <= 1'b1;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (halt_s && !pend_q) begin
            state_q <= ST_HALT; // RULE10
          end else if (fall_tick && pend_q && !int_any) begin
            state_q <= ST_CMD;
            cd_q <= 1'b0; // RULE5
            case (kind_q)
              XFER_LOAD_CODE: nib_q <= `CMD_LOAD_CODE_PTR; // RULE15
              XFER_LOAD_DATA: nib_q <= `CMD_LOAD_DATA_PTR;
              XFER_READ: nib_q <= `CMD_READ;
              default: nib_q <= `CMD_WRITE;
            endcase
          end
        end
        ST_CMD: begin
          if (fall_tick) begin
            cd_q <= 1'b1; // RULE7
            cnt_q <= 4'h0;
            if (is_load) begin
              state_q <= ST_ADDR;
              nib_q <= addr_q[3:0]; // RULE2
            end else begin
              state_q <= ST_DATA;
              nib_q <= (kind_q == XFER_WRITE) ? wdata_q[3:0] : `IDLE_NIBBLE; // RULE17
            end
          end
        end
        ST_ADDR: begin
          if (fall_tick) begin
            if (cnt_q[2:0] == ADDR_LAST) begin
              state_q <= ST_IDLE;
              nib_q <= `IDLE_NIBBLE;
              done_pulse <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 4'h1;
              nib_q <= addr_q[{cnt_q[2:0] + 3'h1, 2'b00} +: 4]; // RULE2
            end
          end
        end
        ST_DATA: begin
          if (fall_tick) begin
            if (cnt_q == last_q) begin
              state_q <= ST_IDLE;
              nib_q <= `IDLE_NIBBLE;
              done_pulse <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 4'h1;
              nib_q <= wdata_q[{cnt_q + 4'h1, 2'b00} +: 4]; // RULE17
            end
          end
        end
        ST_HALT: begin
          if (!halt_s) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read capture on strobe rise, when partner data has settled
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 64'h0;
    end else if (rise_tick && state_q == ST_DATA && kind_q == XFER_READ) begin
      rdata_q[{cnt_q, 2'b00} +: 4] <= bus_in_s; // RULE17
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output register lines
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      output_drive_lines <= `DRIVE_LINES_RST;
    end else if (drive_we) begin
      output_drive_lines <= drive_wdata; // RULE13
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pin drive; strobe, select and nibble lines float while halted for an outside master
  assign bus_clock_pulse_n = strobe_q; // RULE4
  assign command_data_select = cd_q;
  assign nibble_lines_out = nib_q; // RULE1
  assign halted = (state_q == ST_HALT); // RULE11
  assign bus_clock_pulse_oe_n = halted; // RULE10
  assign command_data_select_oe_n = halted;
  assign nibble_lines_oe_n = halted || (state_q == ST_DATA && kind_q == XFER_READ);

  ////////////////////////////////////////////////////////////////
  // Checks
  property p_cmd_select_low;
    @(posedge clk_sys) disable iff (!arst_n)
    (state_q == ST_CMD) |-> (!command_data_select && !nibble_lines_oe_n);
  endproperty
  a_cmd_select_low: assert property (p_cmd_select_low) else $error("select not low in command"); // RULE5

  property p_data_select_high;
    @(posedge clk_sys) disable iff (!arst_n)
    (state_q == ST_ADDR || state_q == ST_DATA) |-> command_data_select;
  endproperty
  a_data_select_high: assert property (p_data_select_high) else $error("select low in data"); // RULE7

  property p_halt_release;
    @(posedge clk_sys) disable iff (!arst_n)
    halted |-> (nibble_lines_oe_n && bus_clock_pulse_oe_n && command_data_select_oe_n);
  endproperty
  a_halt_release: assert property (p_halt_release) else $error("bus driven while halted"); // RULE10

  property p_strobe_period;
    @(posedge clk_sys) disable iff (!arst_n)
    ($changed(bus_clock_pulse_n) && !halted && !$past(halted)) |-> ($past(div_q) == HALF_CYC - 9'h001);
  endproperty
  a_strobe_period: assert property (p_strobe_period) else $error("strobe half period wrong"); // RULE14

  property p_five_addr;
    @(posedge clk_sys) disable iff (!arst_n)
    (state_q == ST_ADDR && fall_tick && cnt_q == 4'h4) |=> (state_q == ST_IDLE && done_pulse);
  endproperty
  a_five_addr: assert property (p_five_addr) else $error("address not five nibbles"); // RULE2

  property p_change_on_fall;
    @(posedge clk_sys) disable iff (!arst_n)
    ($changed(nibble_lines_out) || $changed(command_data_select)) |-> $past(fall_tick);
  endproperty
  a_change_on_fall: assert property (p_change_on_fall) else $error("bus changed off strobe fall"); // RULE17

  property p_word_len;
    @(posedge clk_sys) disable iff (!arst_n)
    (state_q == ST_DATA) |-> (cnt_q <= last_q);
  endproperty
  a_word_len: assert property (p_word_len) else $error("word overran length"); // RULE3

  property p_int_idle;
    @(posedge clk_sys) disable iff (!arst_n)
    int_take |-> ($past(state_q) == ST_IDLE && int_vector == `INT_VECTOR);
  endproperty
  a_int_idle: assert property (p_int_idle) else $error("interrupt taken mid transfer"); // RULE9

  property p_drive_write;
    @(posedge clk_sys) disable iff (!arst_n)
    drive_we |=> (output_drive_lines == $past(drive_wdata));
  endproperty
  a_drive_write: assert property (p_drive_write) else $error("drive lines not updated"); // RULE13

endmodule

/* testbench/nibble_mem_model.sv */
// Behavioural memory chip hanging on the nibble bus.
`timescale 1ns/100ps
`include "nibble_bus_cfg.svh"
module nibble_mem_model (
  input wire logic bus_clock_pulse_n,
  input wire logic command_data_select,
  input wire logic [3:0] nibble_lines_out,
  input wire logic nibble_lines_oe_n,
  output logic [3:0] nibble_lines_in
);
  logic [3:0] mem_q [256];
  logic [19:0] code_ptr_q = 20'h0;
  logic [19:0] data_ptr_q = 20'h0;
  logic [3:0] cmd_q = 4'h0;
  logic [2:0] cnt_q = 3'h0;
  logic [3:0] last_q = 4'h0;
  logic is_load;
  ////////////////////////////////////////
  initial begin
    foreach (mem_q[i]) mem_q[i] = 4'h0;
  end
  // Wire level: master when enabled, else the chip sources read data during a read command
  // Released bus shows inverse of last value, never a stale copy
  assign nibble_lines_in = !nibble_lines_oe_n ? nibble_lines_out :
    (cmd_q == `CMD_READ) ? mem_q[data_ptr_q[7:0]] : ~last_q;
  assign is_load = cmd_q == `CMD_LOAD_CODE_PTR || cmd_q == `CMD_LOAD_DATA_PTR;
  ////////////////////////////////////////
  // Latch on rising strobe; idle strobes keep streaming like real parts
  always @(posedge bus_clock_pulse_n) begin
    last_q <= nibble_lines_in;
    if (command_data_select === 1'b0) begin
      cmd_q <= nibble_lines_in;
      cnt_q <= 3'h0;
    end else if (is_load && cnt_q < 3'h5) begin
      if (cmd_q == `CMD_LOAD_CODE_PTR) code_ptr_q[4*cnt_q +: 4] <= nibble_lines_in;
      else data_ptr_q[4*cnt_q +: 4] <= nibble_lines_in;
      cnt_q <= cnt_q + 3'h1;
    end else if (cmd_q == `CMD_READ || cmd_q == `CMD_WRITE) begin
      if (cmd_q == `CMD_WRITE) mem_q[data_ptr_q[7:0]] <= nibble_lines_in;
      data_ptr_q <= data_ptr_q + 20'h1;
    end
  end
endmodule

/* testbench/nibble_bus_master_interface_test.sv */
// Self-checking bench for the nibble bus master.
`timescale 1ns/100ps
`include "nibble_bus_cfg.svh"
module nibble_bus_master_interface_test;
  import nibble_bus_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  xfer_kind_t req_kind = XFER_READ;
  logic [19:0] req_addr = 20'h0;
  logic [3:0] req_last = 4'h0;
  logic [63:0] req_wdata = 64'h0;
  logic drive_we = 1'b0;
  logic [11:0] drive_wdata = 12'h000;
  logic module_int_n = 1'b1;
  logic halt = 1'b0;
  logic [15:0] sense = 16'h0000;
  logic req_ready, done_pulse, int_take, int_mod, key_hit, halted;
  logic [63:0] rdata_q;
  logic [19:0] int_vector;
  logic [15:0] sense_level;
  logic [11:0] drive_lines;
  logic [3:0] nib_in, nib_out;
  logic nib_oe_n, strobe_n, strobe_oe_n, sel, sel_oe_n;
  int error_cnt = 0;
  int samples_checked = 0;
  ////////////////////////////////////////
  nibble_bus_master_interface u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind),
    .req_addr(req_addr), .req_last(req_last), .req_wdata(req_wdata),
    .done_pulse(done_pulse), .rdata_q(rdata_q), .int_take(int_take),
    .int_from_module(int_mod), .int_vector(int_vector), .key_hit(key_hit),
    .sense_level(sense_level), .drive_we(drive_we), .drive_wdata(drive_wdata),
    .output_drive_lines(drive_lines), .nibble_lines_in(nib_in),
    .nibble_lines_out(nib_out), .nibble_lines_oe_n(nib_oe_n),
    .bus_clock_pulse_n(strobe_n), .bus_clock_pulse_oe_n(strobe_oe_n),
    .command_data_select(sel), .command_data_select_oe_n(sel_oe_n),
    .module_int_n(module_int_n), .halt(halt), .input_sense_lines(sense),
    .halted(halted));
  nibble_mem_model u_mem (.bus_clock_pulse_n(strobe_n), .command_data_select(sel),
    .nibble_lines_out(nib_out), .nibble_lines_oe_n(nib_oe_n), .nibble_lines_in(nib_in));
  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Request is raised at a falling edge and held one full cycle
  task automatic xfer(input xfer_kind_t k, input logic [19:0] a, input logic [3:0] l,
      input logic [63:0] w, input logic [3:0] cmd, input int exp_falls);
    int falls;
    int n;
    logic prev;
    falls = 0;
    n = 0;
    while (req_ready !== 1'b1) @(negedge clk_sys);
    req_kind = k;
    req_addr = a;
    req_last = l;
    req_wdata = w;
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    prev = strobe_n;
    while (done_pulse !== 1'b1 && n < 8000) begin
      @(negedge clk_sys);
      n++;
      if (prev === 1'b1 && strobe_n === 1'b0) begin
        falls++;
        if (falls == 1) chk(sel === 1'b0 && nib_out === cmd, "command nibble");
        else if (done_pulse !== 1'b1) chk(sel === 1'b1, "select during data");
        if (falls == 2 && k == XFER_WRITE) chk(nib_out === w[3:0], "first nibble");
      end
      prev = strobe_n;
    end
    chk(falls == exp_falls, "strobe count of transfer");
  endtask
  task automatic wait_take(input logic from_mod);
    int n;
    n = 0;
    while (int_take !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    chk(int_take === 1'b1 && int_mod === from_mod, "interrupt source");
  endtask
  ////////////////////////////////////////
  task automatic t_strobe();
    int n;
    n = 0;
    @(negedge strobe_n);
    @(negedge clk_sys);
    // Count through the low half, then the high half, up to the next fall
    while (strobe_n !== 1'b1 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    while (strobe_n !== 1'b0 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n == 2 * `STROBE_HALF_CYC, "strobe period");
  endtask
  task automatic t_transfers();
    xfer(XFER_LOAD_CODE, 20'habcde, 4'h0, 64'h0, `CMD_LOAD_CODE_PTR, 7);
    chk(u_mem.code_ptr_q === 20'habcde, "code pointer");
    xfer(XFER_LOAD_DATA, 20'h00010, 4'h0, 64'h0, `CMD_LOAD_DATA_PTR, 7);
    chk(u_mem.data_ptr_q === 20'h00010, "data pointer");
    xfer(XFER_WRITE, 20'h0, 4'hf, 64'hfedcba9876543210, `CMD_WRITE, 18);
    xfer(XFER_LOAD_DATA, 20'h00010, 4'h0, 64'h0, `CMD_LOAD_DATA_PTR, 7);
    xfer(XFER_READ, 20'h0, 4'hf, 64'h0, `CMD_READ, 18);
    chk(rdata_q === 64'hfedcba9876543210, "sixteen nibble read");
    xfer(XFER_LOAD_DATA, 20'h00013, 4'h0, 64'h0, `CMD_LOAD_DATA_PTR, 7);
    xfer(XFER_READ, 20'h0, 4'h0, 64'h0, `CMD_READ, 3);
    chk(rdata_q[3:0] === 4'h3, "single nibble read");
  endtask
  task automatic t_int();
    module_int_n = 1'b0;
    wait_take(1'b1);
    chk(int_vector === `INT_VECTOR, "interrupt entry");
    module_int_n = 1'b1;
    repeat (700) @(negedge clk_sys);
    sense = 16'h4000;
    repeat (10) @(negedge clk_sys);
    chk(key_hit === 1'b0 && sense_level === 16'h4000, "general-only line");
    wait_take(1'b0);
    sense = 16'h0000;
    repeat (700) @(negedge clk_sys);
    sense = 16'h8000;
    wait_take(1'b0);
    chk(key_hit === 1'b1, "power key line");
    sense = 16'h0000;
  endtask
  task automatic t_drive();
    drive_wdata = 12'ha5c;
    drive_we = 1'b1;
    @(negedge clk_sys);
    drive_we = 1'b0;
    chk(drive_lines === 12'ha5c, "drive lines");
  endtask
  task automatic t_halt();
    int n;
    n = 0;
    repeat (20) @(negedge clk_sys);
    halt = 1'b1;
    while (halted !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    chk(nib_oe_n === 1'b1 && strobe_oe_n === 1'b1 && sel_oe_n === 1'b1, "bus freed");
    chk(req_ready === 1'b0, "no request while halted");
    halt = 1'b0;
    repeat (20) @(negedge clk_sys);
    chk(halted === 1'b0 && strobe_oe_n === 1'b0, "bus taken back");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk_sys);
    chk(strobe_n === 1'b1 && sel === 1'b1 && drive_lines === 12'h000, "reset");
    arst_n = 1'b1;
    @(negedge clk_sys);
    t_strobe();
    t_transfers();
    t_int();
    t_drive();
    t_halt();
    final_report();
  end
  // Watchdog: tests need about 24000 cycles
  initial begin
    #(5 * 60000);
    error_cnt++;
    final_report();
  end
endmodule
